// ==== common/eccfi_params.svh ====
`ifndef ECCFI_PARAMS_SVH
`define ECCFI_PARAMS_SVH

// Register offsets on the peripheral register bus
`define ECCFI_OFS_CTRL 8'h00
`define ECCFI_OFS_ADDR 8'h04
`define ECCFI_OFS_MSTR 8'h08
`define ECCFI_OFS_ATTR 8'h0C
`define ECCFI_OFS_DATA 8'h10

// Control register field positions
`define ECCFI_POS_LSB 0
`define ECCFI_POS_MSB 6
`define ECCFI_BIT_DBL_ONCE 8
`define ECCFI_BIT_DBL_CONT 9
`define ECCFI_BIT_SGL_ONCE 10
`define ECCFI_BIT_SGL_CONT 11
`define ECCFI_CTRL_WMASK 16'h0F7F

// Reset values
`define ECCFI_CTRL_RST 16'h0000
`define ECCFI_CAP_RST 32'h0000_0000

// Error position ranges
`define ECCFI_POS_DATA_HI 7'h1F
`define ECCFI_POS_CHK_LO 7'h40
`define ECCFI_POS_CHK_HI 7'h46

// Code word layout: data in the low bits, check bits above
`define ECCFI_DATA_W 32
`define ECCFI_CHK_W 7
`define ECCFI_PARITY_BIT 32

`endif

// ==== common/eccfi_pkg.sv ====
package eccfi_pkg;

    typedef struct packed {
        logic [6:0] check;
        logic [31:0] data;
    } eccfi_code_t;

    typedef struct packed {
        logic write;
        logic [2:0] size;
        logic [3:0] prot;
    } eccfi_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] master;
        eccfi_attr_t attr;
        logic [31:0] data;
    } eccfi_flash_evt_t;

endpackage

// ==== rtl/eccfi_inject.sv ====
`include "eccfi_params.svh"

module eccfi_inject import eccfi_pkg::*; (
    input wire logic [6:0] error_position_i,
    input wire logic double_i,
    output logic [38:0] mask_o
);
    logic [38:0] sel;

    always_comb begin
        sel = 39'h0;
        if (error_position_i <= `ECCFI_POS_DATA_HI) begin
            sel[error_position_i[4:0]] = 1'b1; // R8
        end else if (error_position_i >= `ECCFI_POS_CHK_LO &&
                     error_position_i <= `ECCFI_POS_CHK_HI) begin
            sel[`ECCFI_DATA_W + 32'(error_position_i[2:0])] = 1'b1; // R9
        end
        // Check bit 0 is the overall parity; a double force at position 64 cancels itself
        mask_o = sel; // R10
        if (double_i && sel != 39'h0) begin
            mask_o[`ECCFI_PARITY_BIT] = ~sel[`ECCFI_PARITY_BIT]; // R4 R5 R11
        end
    end

endmodule // eccfi_inject

// ==== rtl/eccfi_top.sv ====
// Contract
// [R1] Continuous single force flips selected bit always
// [R2] One-shot single force flips first write only
// [R3] Flip applied after normal check bit encoding
// [R4] Continuous double force flips bit plus parity
// [R5] One-shot double force, first write only
// [R6] Software clears a force before setting again
// [R7] Single forces settable only with enable input
// [R8] Positions 0..31 select data bits
// [R9] Positions 64..70 select check bits 0..6
// [R10] Positions 32..63 and above 70 flip nothing
// [R11] Double force at position 64 flips nothing
// [R12] Software sets at most one force
// [R13] Corrupted word later raises an ECC event
// [R14] Enabled flash event loads capture, sets flag
// [R15] Capture registers read-only, writes ignored
// [R16] Address capture holds full faulting address
// [R17] Master capture holds four-bit master number
// [R18] Attributes record write direction
// [R19] Attributes record transfer size
// [R20] Attributes record four protection bits
// [R21] Flash events captured only when enabled
// [R22] One flag at a time, fixed priority
// [R23] Forces and position zero after reset
`include "eccfi_params.svh"

module eccfi_top import eccfi_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic rb_sel_i,
    input wire logic rb_wr_i,
    input wire logic [7:0] rb_addr_i,
    input wire logic [31:0] rb_wdata_i,
    output logic [31:0] rb_rdata_o,
    output logic rb_rvalid_o,
    input wire logic single_bit_report_en_i,
    input wire logic flash_single_report_enable_i,
    input wire logic flash_uncorrectable_report_enable_i,
    input wire logic sram_wr_i,
    input wire eccfi_code_t sram_code_i,
    output logic sram_wr_o,
    output eccfi_code_t sram_code_o,
    input wire logic flash_single_evt_i,
    input wire logic flash_uncorr_evt_i,
    input wire eccfi_flash_evt_t flash_evt_i,
    input wire logic sram_single_evt_i,
    input wire logic sram_uncorr_evt_i,
    input wire logic [1:0] flash_flag_clear_i,
    output logic flash_single_corrected_flag_o,
    output logic flash_uncorrectable_flag_o
);

    // Control register and one-shot bookkeeping
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic once_used_q;
    logic once_used_d;
    logic ctrl_wr;
    logic single_act;
    logic double_act;
    logic [6:0] error_position;
    logic [38:0] mask;
    logic [38:0] eff_mask;

    assign ctrl_wr = rb_sel_i && rb_wr_i && (rb_addr_i == `ECCFI_OFS_CTRL);
    assign error_position = ctrl_q[`ECCFI_POS_MSB:`ECCFI_POS_LSB];

    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = rb_wdata_i[15:0] & `ECCFI_CTRL_WMASK;
            if (!single_bit_report_en_i) begin
                // A blocked write may still clear, but never set
                ctrl_d[`ECCFI_BIT_SGL_CONT] =
                    ctrl_d[`ECCFI_BIT_SGL_CONT] & ctrl_q[`ECCFI_BIT_SGL_CONT]; // R7
                ctrl_d[`ECCFI_BIT_SGL_ONCE] =
                    ctrl_d[`ECCFI_BIT_SGL_ONCE] & ctrl_q[`ECCFI_BIT_SGL_ONCE]; // R7
            end
        end
    end

    // Re-armed only by clearing both one-shot bits; a direct swap stays spent
    always_comb begin
        once_used_d = once_used_q;
        if (!ctrl_q[`ECCFI_BIT_SGL_ONCE] && !ctrl_q[`ECCFI_BIT_DBL_ONCE]) begin
            once_used_d = 1'b0; // R6
        end else if (sram_wr_i) begin
            once_used_d = 1'b1; // R2 R5
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= `ECCFI_CTRL_RST; // R23
            once_used_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            once_used_q <= once_used_d;
        end
    end

    // Combinations of several forces are undefined; no arbitration spent on them
    assign single_act = ctrl_q[`ECCFI_BIT_SGL_CONT] ||
                        (ctrl_q[`ECCFI_BIT_SGL_ONCE] && !once_used_q); // R1 R2
    assign double_act = ctrl_q[`ECCFI_BIT_DBL_CONT] ||
                        (ctrl_q[`ECCFI_BIT_DBL_ONCE] && !once_used_q); // R4 R5

    eccfi_inject u_inject (
        .error_position_i(error_position),
        .double_i(double_act),
        .mask_o(mask)
    );

    assign eff_mask = (single_act || double_act) ? mask : 39'h0;

    // SRAM write path: one register stage after the encoder
    logic sram_wr_q;
    logic sram_wr_d;
    eccfi_code_t code_q;
    eccfi_code_t code_d;

    always_comb begin
        sram_wr_d = sram_wr_i;
        code_d = code_q;
        if (sram_wr_i) begin
            code_d = sram_code_i ^ eff_mask; // R3 R13
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sram_wr_q <= 1'b0;
            code_q <= 39'h0;
        end else begin
            sram_wr_q <= sram_wr_d;
            code_q <= code_d;
        end
    end

    assign sram_wr_o = sram_wr_q;
    assign sram_code_o = code_q;

    // Flash capture and status flags
    logic [31:0] cap_addr_q;
    logic [31:0] cap_addr_d;
    logic [3:0] cap_mstr_q;
    logic [3:0] cap_mstr_d;
    eccfi_attr_t cap_attr_q;
    eccfi_attr_t cap_attr_d;
    logic [31:0] cap_data_q;
    logic [31:0] cap_data_d;
    logic [1:0] flag_q;
    logic [1:0] flag_d;
    logic f1_en;
    logic fn_en;
    logic f1_win;
    logic fn_win;
    logic any_evt;

    assign f1_en = flash_single_evt_i && flash_single_report_enable_i; // R21
    assign fn_en = flash_uncorr_evt_i && flash_uncorrectable_report_enable_i; // R21
    assign f1_win = f1_en && !sram_single_evt_i; // R22
    assign fn_win = fn_en && !sram_single_evt_i && !f1_en && !sram_uncorr_evt_i; // R22
    assign any_evt = sram_single_evt_i || sram_uncorr_evt_i || f1_en || fn_en;

    always_comb begin
        cap_addr_d = cap_addr_q;
        cap_mstr_d = cap_mstr_q;
        cap_attr_d = cap_attr_q;
        cap_data_d = cap_data_q;
        // Newest event replaces older flags; set beats a same-cycle clear
        flag_d = flag_q & ~flash_flag_clear_i;
        if (any_evt) begin
            flag_d = {fn_win, f1_win}; // R14 R22
        end
        if (f1_win || fn_win) begin
            cap_addr_d = flash_evt_i.addr; // R14 R16
            cap_mstr_d = flash_evt_i.master; // R17
            cap_attr_d.write = flash_evt_i.attr.write; // R18
            cap_attr_d.size = flash_evt_i.attr.size; // R19
            cap_attr_d.prot = flash_evt_i.attr.prot; // R20
            cap_data_d = flash_evt_i.data; // R14
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_addr_q <= `ECCFI_CAP_RST;
            cap_mstr_q <= 4'h0;
            cap_attr_q <= 8'h00;
            cap_data_q <= `ECCFI_CAP_RST;
            flag_q <= 2'h0;
        end else begin
            cap_addr_q <= cap_addr_d;
            cap_mstr_q <= cap_mstr_d;
            cap_attr_q <= cap_attr_d;
            cap_data_q <= cap_data_d;
            flag_q <= flag_d;
        end
    end

    assign flash_single_corrected_flag_o = flag_q[0];
    assign flash_uncorrectable_flag_o = flag_q[1];

    // Register read port; writes to capture registers have no path in
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic rb_rd;

    assign rb_rd = rb_sel_i && !rb_wr_i;

    always_comb begin
        rvalid_d = rb_rd;
        rdata_d = rdata_q;
        if (rb_rd) begin
            case (rb_addr_i)
                `ECCFI_OFS_CTRL: rdata_d = {16'h0000, ctrl_q};
                `ECCFI_OFS_ADDR: rdata_d = cap_addr_q; // R15
                `ECCFI_OFS_MSTR: rdata_d = {28'h0000000, cap_mstr_q}; // R15
                `ECCFI_OFS_ATTR: rdata_d = {24'h000000, cap_attr_q}; // R15
                `ECCFI_OFS_DATA: rdata_d = cap_data_q; // R15
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rb_rdata_o = rdata_q;
    assign rb_rvalid_o = rvalid_q;

    // Checks
    logic [38:0] diff;
    logic [38:0] code_in_q;
    logic ctrl_only_sgl_cont;
    logic ctrl_no_force;

    // Input word one cycle back, lined up with the registered output
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_in_q <= 39'h0;
        end else begin
            code_in_q <= sram_code_i;
        end
    end

    assign diff = sram_code_o ^ code_in_q;
    assign ctrl_only_sgl_cont = ctrl_q[11:8] == 4'h8;
    assign ctrl_no_force = ctrl_q[11:8] == 4'h0;

    property p_sgl_data;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && ctrl_only_sgl_cont && error_position <= 7'h1F
        |=> diff == (39'h1 << $past(error_position));
    endproperty
    a_sgl_data: assert property (p_sgl_data) // R1 R8
        else $error("continuous single force flipped wrong data bit");

    property p_sgl_check;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && ctrl_only_sgl_cont &&
        error_position >= 7'h40 && error_position <= 7'h46
        |=> diff == (39'h1 << (7'd32 + $past(error_position) - 7'h40));
    endproperty
    a_sgl_check: assert property (p_sgl_check) // R9
        else $error("check bit position mapping wrong");

    property p_once_spent;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && once_used_q && ctrl_q[11:8] == 4'h4 |=> diff == 39'h0;
    endproperty
    a_once_spent: assert property (p_once_spent) // R2
        else $error("one-shot force flipped a second write");

    property p_once_first;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && !once_used_q && ctrl_q[11:8] == 4'h1 &&
        error_position <= 7'h1F
        |=> $countones(diff) == 2 && diff[32] ##1 once_used_q;
    endproperty
    a_once_first: assert property (p_once_first) // R5
        else $error("one-shot double force not applied to first write");

    property p_dbl_cont;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && ctrl_q[11:8] == 4'h2 &&
        error_position >= 7'h41 && error_position <= 7'h46
        |=> $countones(diff) == 2;
    endproperty
    a_dbl_cont: assert property (p_dbl_cont) // R4
        else $error("continuous double force did not flip two bits");

    property p_dbl_64;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && double_act && error_position == 7'h40 |=> diff == 39'h0;
    endproperty
    a_dbl_64: assert property (p_dbl_64) // R11
        else $error("double force at position 64 flipped bits");

    property p_bad_pos;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && ((error_position > 7'h1F && error_position < 7'h40) ||
                      error_position > 7'h46)
        |=> diff == 39'h0;
    endproperty
    a_bad_pos: assert property (p_bad_pos) // R10
        else $error("unused position produced an inversion");

    property p_idle;
        @(posedge ref_clk_i) disable iff (rst_i)
        sram_wr_i && ctrl_no_force |=> diff == 39'h0 && sram_wr_o;
    endproperty
    a_idle: assert property (p_idle) // R3
        else $error("write altered with no force set");

    property p_sgl_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        !single_bit_report_en_i |=> !$rose(ctrl_q[11]) && !$rose(ctrl_q[10]);
    endproperty
    a_sgl_gate: assert property (p_sgl_gate) // R7
        else $error("single force set while enable low");

    property p_capture;
        @(posedge ref_clk_i) disable iff (rst_i)
        f1_en && !sram_single_evt_i
        |=> flash_single_corrected_flag_o && !flash_uncorrectable_flag_o &&
            cap_addr_q == $past(flash_evt_i.addr) &&
            cap_mstr_q == $past(flash_evt_i.master);
    endproperty
    a_capture: assert property (p_capture) // R14 R16 R17
        else $error("flash event not captured");

    property p_disabled;
        @(posedge ref_clk_i) disable iff (rst_i)
        !any_evt |=> $stable(cap_addr_q) && $stable(cap_attr_q) && !$rose(flag_q[1]);
    endproperty
    a_disabled: assert property (p_disabled) // R15 R21
        else $error("capture changed without enabled event");

    property p_one_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        fn_en && (sram_single_evt_i || f1_en || sram_uncorr_evt_i)
        |=> !flash_uncorrectable_flag_o ##1 $onehot0(flag_q);
    endproperty
    a_one_flag: assert property (p_one_flag) // R22
        else $error("lower priority flash flag won");

endmodule // eccfi_top

// ==== tb/eccfi_sram_model.sv ====
module eccfi_sram_model import eccfi_pkg::*; (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [31:0] data_i,
    output logic wr_o,
    output eccfi_code_t code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_o = 1'b0;
        code_o = '0;
    end
    // Encodes first; forced flips are the block's job
    always @(posedge clk_i) begin
        wr_o <= go_i;
        if (go_i) begin
            code_o <= {data_i[30:25] ^ data_i[5:0], ~^data_i, data_i};
        end else begin
            code_o <= ~code_o; // Idle bus must not show a stale word
        end
    end
endmodule // eccfi_sram_model

// ==== tb/tb_ecc_error_inject_and_flash_capture.sv ====
module tb_ecc_error_inject_and_flash_capture import eccfi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid;
    logic sbr_en = 1'b1;
    logic [1:0] fen = 2'h3;
    logic go = 1'b0;
    logic [31:0] dat = 32'h0;
    logic swr;
    eccfi_code_t scode;
    logic swr_o;
    eccfi_code_t scode_o;
    logic fs = 1'b0;
    logic fu = 1'b0;
    logic ss = 1'b0;
    logic su = 1'b0;
    eccfi_flash_evt_t fev = '0;
    logic [1:0] fclr = 2'h0;
    logic flag1;
    logic flag2;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] rq[$];
    logic [38:0] cq[$];
    logic [6:0] pos[10] = '{7'h00, 7'h05, 7'h1F, 7'h20, 7'h3F, 7'h40, 7'h41, 7'h46, 7'h47, 7'h7F};

    eccfi_sram_model u_sram (.clk_i(clk), .go_i(go), .data_i(dat), .wr_o(swr), .code_o(scode));

    eccfi_top dut (.ref_clk_i(clk), .rst_i(rst), .rb_sel_i(sel), .rb_wr_i(wr),
        .rb_addr_i(addr), .rb_wdata_i(wdata), .rb_rdata_o(rdata), .rb_rvalid_o(rvalid),
        .single_bit_report_en_i(sbr_en), .flash_single_report_enable_i(fen[0]),
        .flash_uncorrectable_report_enable_i(fen[1]), .sram_wr_i(swr), .sram_code_i(scode),
        .sram_wr_o(swr_o), .sram_code_o(scode_o), .flash_single_evt_i(fs),
        .flash_uncorr_evt_i(fu), .flash_evt_i(fev), .sram_single_evt_i(ss),
        .sram_uncorr_evt_i(su), .flash_flag_clear_i(fclr),
        .flash_single_corrected_flag_o(flag1), .flash_uncorrectable_flag_o(flag2));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp39(input logic [38:0] got, input logic [38:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Results are matched in arrival order
    always @(negedge clk) begin
        if (rvalid === 1'b1) begin
            cmp32(rdata, rq.size() > 0 ? rq.pop_front() : 32'hX);
        end
        if (swr_o === 1'b1) begin
            cmp39(scode_o, cq.size() > 0 ? cq.pop_front() : 39'hX);
        end
    end

    function automatic logic [38:0] emask(input logic [6:0] p, input logic dbl);
        logic [38:0] m;
        m = '0;
        if (p <= 7'h1F) begin
            m[p] = 1'b1;
        end else if (p >= 7'h40 && p <= 7'h46) begin
            m[p - 7'h20] = 1'b1;
        end
        // Parity flip only rides along with a real flip
        if (dbl && m != '0) begin
            m[32] = ~m[32];
        end
        return m;
    endfunction

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        sel = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        acc(1'b0, a, 32'h0);
    endtask

    // Back-to-back writes: first gets mf, the rest mr
    task automatic sw(input int n, input logic [38:0] mf, input logic [38:0] mr);
        for (int i = 0; i <= n; i++) begin
            @(negedge clk);
            if (i > 0) begin
                cq.push_back(scode ^ (i == 1 ? mf : mr));
            end
            go = (i < n);
            dat = $urandom;
        end
    endtask

    task automatic fevt(input logic s, input logic u, input logic rs);
        @(negedge clk);
        fs = s;
        fu = u;
        ss = rs;
        @(negedge clk);
        fs = 1'b0;
        fu = 1'b0;
        ss = 1'b0;
    endtask

    task automatic flags(input logic [1:0] exp);
        cmp32({30'h0, flag2, flag1}, {30'h0, exp});
    endtask

    task automatic done(input string s);
        repeat (3) @(negedge clk);
        $display("test %0s done", s);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        logic [6:0] p;
        eccfi_flash_evt_t e;
        void'($urandom(28));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h0);
        flags(2'h0);
        done("reset");
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 10; k++) begin
                acc(1'b1, 8'h00, (d ? 32'h200 : 32'h800) | pos[k]);
                rd(8'h00, (d ? 32'h200 : 32'h800) | pos[k]);
                sw(2, emask(pos[k], d[0]), emask(pos[k], d[0]));
                acc(1'b1, 8'h00, 32'h0);
            end
        end
        done("positions");
        for (int d = 0; d < 2; d++) begin
            p = 7'($urandom_range(31));
            acc(1'b1, 8'h00, (d ? 32'h100 : 32'h400) | p);
            sw(3, emask(p, d[0]), 39'h0);
            acc(1'b1, 8'h00, 32'h0);
            acc(1'b1, 8'h00, (d ? 32'h100 : 32'h400) | p);
            sw(1, emask(p, d[0]), 39'h0);
            acc(1'b1, 8'h00, 32'h0);
        end
        done("one-shot");
        sbr_en = 1'b0;
        acc(1'b1, 8'h00, 32'hC05);
        rd(8'h00, 32'h005);
        sw(1, 39'h0, 39'h0);
        sbr_en = 1'b1;
        acc(1'b1, 8'h00, 32'h0);
        done("enable");
        for (int k = 0; k < 3; k++) begin
            e.addr = $urandom;
            e.master = 4'($urandom);
            e.attr = eccfi_attr_t'(8'($urandom));
            e.attr.size = 3'(k);
            e.data = $urandom;
            fev = e;
            fevt(1'b1, 1'b0, 1'b0);
            flags(2'h1);
            rd(8'h04, e.addr);
            rd(8'h08, {28'h0, e.master});
            rd(8'h0C, {24'h0, e.attr});
            rd(8'h10, e.data);
        end
        acc(1'b1, 8'h04, ~e.addr);
        acc(1'b1, 8'h08, 32'hF);
        rd(8'h04, e.addr);
        rd(8'h08, {28'h0, e.master});
        fen = 2'h1;
        fev = ~e;
        fevt(1'b0, 1'b1, 1'b0);
        flags(2'h1);
        rd(8'h04, e.addr);
        fen = 2'h3;
        fevt(1'b1, 1'b1, 1'b0);
        flags(2'h1);
        fevt(1'b1, 1'b0, 1'b1);
        flags(2'h0);
        fevt(1'b0, 1'b1, 1'b0);
        flags(2'h2);
        @(negedge clk);
        fclr = 2'h2;
        @(negedge clk);
        fclr = 2'h0;
        flags(2'h0);
        fevt(1'b0, 1'b1, 1'b0);
        flags(2'h2);
        su = 1'b1;
        fevt(1'b0, 1'b1, 1'b0);
        flags(2'h0);
        su = 1'b0;
        done("flash");
        end_sim();
    end
endmodule // tb_ecc_error_inject_and_flash_capture
